// ==== ccs_device.sv ====
// Device end: configuration sequencer with parallel byte loading
// Rules from the document, for both ends of the link
// R1: Config request low starts new reconfiguration
// R2: Status held low during power-on delay
// R3: Load-complete low until configuration done
// R4: Host drives load clock steady afterwards
// R5: Data pins become user I/O after
// R6: Load-complete low within 50 ns
// R7: Status low within 50 ns
// R8: Status low pulse at most 230 us
// R9: Status released within 230 us
// R10: Host waits 230 us before clocking
// R11: No self reconfiguration; restart command only
// R12: Restart resets master logic and loader
// R13: I/O chain load accepted in user mode
// R14: Host reconfigures after JTAG testing
// R15: No I/O load while request low
// R16: Host waits 230 us before I/O load
// R17: After power-up wait before I/O load
// R18: Chip-enable input negotiates flash ownership
// R19: Chip-enable low for JTAG configuration
// R20: Boundary-scan length 1006 or 1495
// R21: One byte per rising load clock
// R22: Open-drain shared status and done lines
`timescale 1ns/100ps
`include "ccs_params.svh"
module ccs_device #(
  parameter int unsigned POR_CYC    = `CCS_POR_CYC,
  parameter int unsigned STATUS_CYC = `CCS_LATE_REL_CYC,
  parameter int unsigned BYTES_NEED = 16,
  parameter bit          LARGE_PKG  = 1'b0
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  ccs_link_if.device                    link,
  output      logic                     user_mode,
  output      logic                     loader_active,
  output      ccs_pkg::ccs_byte_t       cfg_byte,
  output      logic                     cfg_byte_valid,
  output      ccs_pkg::ccs_byte_t       user_io_in,
  output      logic                     io_chain_reload,
  output      logic [`CCS_BSR_W-1:0]    bsr_length
);
  import ccs_pkg::*;

  typedef enum {ST_POR, ST_RESET, ST_WAIT, ST_LOAD, ST_USER} ccs_dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers on request, load clock and status (second and third must agree); two-stage on load data
  logic [2:0] req_s_r, clk_s_r, ok_s_r;
  logic       req_r, lclk_r, ok_r;
  logic       req_nxt, lclk_nxt, ok_nxt;
  ccs_byte_t  d_s1_r, d_s2_r;

  always_comb begin
    req_nxt  = (req_s_r[1] == req_s_r[2]) ? req_s_r[2] : req_r;
    lclk_nxt = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : lclk_r;
    ok_nxt   = (ok_s_r[1] == ok_s_r[2]) ? ok_s_r[2] : ok_r;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_s_r <= 3'h7;
      clk_s_r <= 3'h0;
      ok_s_r  <= 3'h0;
      req_r   <= 1'b1;
      lclk_r  <= 1'b0;
      ok_r    <= 1'b0;
      d_s1_r  <= 8'h00;
      d_s2_r  <= 8'h00;
    end else begin
      req_s_r <= {req_s_r[1:0], link.config_request_n};
      clk_s_r <= {clk_s_r[1:0], link.load_clock};
      ok_s_r  <= {ok_s_r[1:0], link.cfg_ok_line};
      req_r   <= req_nxt;
      lclk_r  <= lclk_nxt;
      ok_r    <= ok_nxt;
      d_s1_r  <= link.load_data;
      d_s2_r  <= d_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ccs_dev_state_t            st_r, st_nxt;
  logic [`CCS_CNT_W-1:0]     cnt_r, cnt_nxt;
  logic [`CCS_BYTE_CNT_W-1:0] nbyte_r, nbyte_nxt;
  logic                      ok_low_r, ok_low_nxt;
  logic                      done_low_r, done_low_nxt;
  logic                      user_r, user_nxt;
  logic                      loader_r, loader_nxt;
  ccs_byte_t                 byte_r, byte_nxt;
  logic                      bval_r, bval_nxt;
  ccs_byte_t                 uio_r, uio_nxt;
  logic                      ioreload_r, ioreload_nxt;
  logic                      lclk_d_r;
  logic                      lclk_rise;
  logic                      restart_cmd, io_cmd;

  assign lclk_rise   = lclk_r && !lclk_d_r;
  assign restart_cmd = link.jtag_cmd_valid && link.jtag_cmd == CCS_CMD_RESTART;
  assign io_cmd      = link.jtag_cmd_valid && link.jtag_cmd == CCS_CMD_IO_LOAD;

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    nbyte_nxt    = nbyte_r;
    ok_low_nxt   = ok_low_r;
    done_low_nxt = done_low_r;
    user_nxt     = user_r;
    loader_nxt   = loader_r;
    byte_nxt     = byte_r;
    bval_nxt     = 1'b0;
    uio_nxt      = uio_r;
    ioreload_nxt = 1'b0;
    case (st_r)
      ST_POR: begin
        ok_low_nxt   = 1'b1; // R2
        done_low_nxt = 1'b1; // R3
        cnt_nxt      = cnt_r + 1'b1;
        if (cnt_r >= `CCS_CNT_W'(POR_CYC - 1)) begin
          st_nxt  = ST_WAIT;
          cnt_nxt = '0;
        end
      end
      ST_RESET: begin
        ok_low_nxt   = 1'b1; // R7
        done_low_nxt = 1'b1; // R6
        user_nxt     = 1'b0;
        loader_nxt   = 1'b0; // R12
        nbyte_nxt    = '0;
        cnt_nxt      = '0;
        if (req_r) begin
          st_nxt = ST_WAIT; // R9
        end
      end
      ST_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= `CCS_CNT_W'(STATUS_CYC - 1)) begin
          ok_low_nxt = 1'b0; // R8 R9 R22
          st_nxt     = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (lclk_rise && !link.chip_select_in_n) begin // R18 R21
          byte_nxt  = d_s2_r;
          bval_nxt  = 1'b1;
          nbyte_nxt = nbyte_r + 1'b1;
          if (nbyte_r == `CCS_BYTE_CNT_W'(BYTES_NEED - 1)) begin
            done_low_nxt = 1'b0; // R22
            st_nxt       = ST_USER;
          end
        end
      end
      ST_USER: begin
        user_nxt = ok_r; // R22
        if (user_r) begin
          uio_nxt = d_s2_r; // R5
        end
        if (io_cmd && req_r && user_r) begin
          ioreload_nxt = 1'b1; // R13
        end
      end
      default: st_nxt = ST_POR;
    endcase
    // Request low or restart command aborts from anywhere but power-on
    if (st_r != ST_POR && (!req_r || restart_cmd)) begin // R1 R11
      st_nxt       = ST_RESET;
      ok_low_nxt   = 1'b1;
      done_low_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= ST_POR;
      cnt_r      <= '0;
      nbyte_r    <= '0;
      ok_low_r   <= 1'b1;
      done_low_r <= 1'b1;
      user_r     <= 1'b0;
      loader_r   <= 1'b1;
      byte_r     <= 8'h00;
      bval_r     <= 1'b0;
      uio_r      <= 8'h00;
      ioreload_r <= 1'b0;
      lclk_d_r   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      nbyte_r    <= nbyte_nxt;
      ok_low_r   <= ok_low_nxt;
      done_low_r <= done_low_nxt;
      user_r     <= user_nxt;
      loader_r   <= loader_nxt;
      byte_r     <= byte_nxt;
      bval_r     <= bval_nxt;
      uio_r      <= uio_nxt;
      ioreload_r <= ioreload_nxt;
      lclk_d_r   <= lclk_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins: enable low only when pulling low
  assign link.dev_ok_o      = 1'b0;
  assign link.dev_ok_oe_n   = !ok_low_r;   // R22
  assign link.dev_done_o    = 1'b0;
  assign link.dev_done_oe_n = !done_low_r; // R22

  assign user_mode       = user_r;
  assign loader_active   = loader_r;
  assign cfg_byte        = byte_r;
  assign cfg_byte_valid  = bval_r;
  assign user_io_in      = uio_r;
  assign io_chain_reload = ioreload_r;
  assign bsr_length      = LARGE_PKG ? `CCS_BSR_W'(`CCS_BSR_LARGE)
                                     : `CCS_BSR_W'(`CCS_BSR_SMALL); // R20
endmodule : ccs_device

// ==== ccs_host.sv ====
// Host end: drives request, load clock and bytes, issues JTAG commands
`timescale 1ns/100ps
`include "ccs_params.svh"
module ccs_host #(
  parameter int unsigned WAIT_CYC = `CCS_WAIT_MIN_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  ccs_link_if.host                 link,
  input  wire logic                start_cfg,
  input  wire logic                jtag_restart_req,
  input  wire logic                jtag_engage_req,
  input  wire logic                io_load_req,
  input  wire ccs_pkg::ccs_byte_t  tx_byte,
  input  wire logic                tx_valid,
  output      logic                tx_ready,
  output      logic                host_busy,
  output      logic                io_load_refused
);
  import ccs_pkg::*;

  typedef enum {HS_IDLE, HS_PULSE, HS_WAIT, HS_LOAD_LO, HS_LOAD_HI} ccs_host_state_t;

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]            ok_s_r;
  logic                  ok_r, ok_nxt;
  ccs_host_state_t       st_r, st_nxt;
  logic [`CCS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`CCS_CNT_W-1:0] iow_r, iow_nxt;
  logic                  req_n_r, req_n_nxt;
  logic                  lclk_r, lclk_nxt;
  ccs_byte_t             dat_r, dat_nxt;
  ccs_jtag_cmd_t         cmd_r, cmd_nxt;
  logic                  cmdv_r, cmdv_nxt;
  logic                  rdy_r, rdy_nxt;
  logic                  ref_r, ref_nxt;
  logic                  pu_r, pu_nxt;
  logic                  busy_r, busy_nxt;

  always_comb begin
    ok_nxt    = (ok_s_r[1] == ok_s_r[2]) ? ok_s_r[2] : ok_r;
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    iow_nxt   = (iow_r != '0) ? iow_r - 1'b1 : iow_r;
    req_n_nxt = req_n_r;
    lclk_nxt  = lclk_r;
    dat_nxt   = dat_r;
    cmd_nxt   = CCS_CMD_NONE;
    cmdv_nxt  = 1'b0;
    rdy_nxt   = 1'b0;
    ref_nxt   = 1'b0;
    pu_nxt    = pu_r;
    // Status-high shortcut only counts after power-up, never after a restart or engage
    if (pu_r && ok_r && iow_r > `CCS_CNT_W'(0) && st_r == HS_IDLE) begin
      iow_nxt = '0; // R17
    end
    case (st_r)
      HS_IDLE: begin
        if (start_cfg) begin
          req_n_nxt = 1'b0; // R14
          cnt_nxt   = '0;
          pu_nxt    = 1'b0;
          st_nxt    = HS_PULSE;
        end else if (jtag_restart_req || jtag_engage_req) begin
          cmd_nxt  = jtag_restart_req ? CCS_CMD_RESTART : CCS_CMD_ENGAGE;
          cmdv_nxt = 1'b1;
          iow_nxt  = `CCS_CNT_W'(WAIT_CYC); // R16
          cnt_nxt  = '0;
          pu_nxt   = 1'b0;
          st_nxt   = jtag_restart_req ? HS_WAIT : HS_IDLE;
        end else if (io_load_req) begin
          if (iow_r == '0 && req_n_r) begin // R15 R16
            cmd_nxt  = CCS_CMD_IO_LOAD;
            cmdv_nxt = 1'b1;
          end else begin
            ref_nxt = 1'b1;
          end
        end
      end
      HS_PULSE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= `CCS_CNT_W'(`CCS_CFG_LOW_CYC - 1)) begin
          req_n_nxt = 1'b1;
          cnt_nxt   = '0;
          iow_nxt   = `CCS_CNT_W'(WAIT_CYC); // R16
          st_nxt    = HS_WAIT;
        end
      end
      HS_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= `CCS_CNT_W'(WAIT_CYC - 1)) begin // R10
          cnt_nxt = '0;
          rdy_nxt = 1'b1;
          st_nxt  = HS_LOAD_LO;
        end
      end
      HS_LOAD_LO: begin
        rdy_nxt = rdy_r;
        cnt_nxt = cnt_r + 1'b1;
        if (link.load_complete) begin
          lclk_nxt = 1'b0; // R4
          st_nxt   = HS_IDLE;
        end else if (rdy_r && tx_valid) begin
          dat_nxt = tx_byte;
          rdy_nxt = 1'b0;
          cnt_nxt = '0;
        end else if (!rdy_r && cnt_r >= `CCS_CNT_W'(`CCS_LCLK_HALF_CYC - 1)) begin
          lclk_nxt = 1'b1; // R21
          cnt_nxt  = '0;
          st_nxt   = HS_LOAD_HI;
        end
      end
      HS_LOAD_HI: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r >= `CCS_CNT_W'(`CCS_LCLK_HALF_CYC - 1)) begin
          lclk_nxt = 1'b0;
          cnt_nxt  = '0;
          rdy_nxt  = 1'b1;
          st_nxt   = HS_LOAD_LO;
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
    // A chain load asked for mid-sequence is turned away, not silently lost
    if (io_load_req && st_r != HS_IDLE) begin
      ref_nxt = 1'b1; // R15 R16
    end
    busy_nxt = (st_nxt != HS_IDLE);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ok_s_r  <= 3'h0;
      ok_r    <= 1'b0;
      st_r    <= HS_IDLE;
      cnt_r   <= '0;
      iow_r   <= `CCS_CNT_W'(WAIT_CYC);
      req_n_r <= 1'b1;
      lclk_r  <= 1'b0;
      dat_r   <= 8'h00;
      cmd_r   <= CCS_CMD_NONE;
      cmdv_r  <= 1'b0;
      rdy_r   <= 1'b0;
      ref_r   <= 1'b0;
      pu_r    <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      ok_s_r  <= {ok_s_r[1:0], link.cfg_ok_line};
      ok_r    <= ok_nxt;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      iow_r   <= iow_nxt;
      req_n_r <= req_n_nxt;
      lclk_r  <= lclk_nxt;
      dat_r   <= dat_nxt;
      cmd_r   <= cmd_nxt;
      cmdv_r  <= cmdv_nxt;
      rdy_r   <= rdy_nxt;
      ref_r   <= ref_nxt;
      pu_r    <= pu_nxt;
      busy_r  <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.config_request_n = req_n_r;
  assign link.load_clock       = lclk_r;
  assign link.load_data        = dat_r;
  assign link.chip_select_in_n = 1'b0; // R19
  assign link.jtag_cmd         = cmd_r;
  assign link.jtag_cmd_valid   = cmdv_r;
  assign link.host_ok_o        = 1'b0;
  assign link.host_ok_oe_n     = 1'b1;
  assign link.host_done_o      = 1'b0;
  assign link.host_done_oe_n   = 1'b1;
  assign tx_ready        = rdy_r;
  assign host_busy       = busy_r;
  assign io_load_refused = ref_r;
endmodule : ccs_host

// ==== ccs_link_chk.sv ====
// Assertions on the pins between host and device
`timescale 1ns/100ps
module ccs_link_chk #(
  parameter int POR_CYC    = 20,
  parameter int STATUS_CYC = 20,
  parameter int WAIT_CYC   = 40
) (
  input wire logic                   sys_clk,
  input wire logic                   sys_rst,
  input wire logic                   config_request_n,
  input wire logic                   load_clock,
  input wire ccs_pkg::ccs_jtag_cmd_t jtag_cmd,
  input wire logic                   jtag_cmd_valid,
  input wire logic                   cfg_ok_line,
  input wire logic                   load_complete
);
  import ccs_pkg::*;
  // Slack of two cycles covers the host counting from its own edge
  localparam logic [15:0] REL_MAX = 16'(POR_CYC + STATUS_CYC + 16);
  localparam logic [15:0] WAIT_L  = 16'(WAIT_CYC - 2);
  logic [15:0] since_r, since_nxt, lowc_r, lowc_nxt;
  logic        pu_r, pu_nxt, req_q_r, evt;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    evt = (config_request_n && !req_q_r) || (jtag_cmd_valid &&
          (jtag_cmd == CCS_CMD_RESTART || jtag_cmd == CCS_CMD_ENGAGE));
    since_nxt = evt ? 16'h0 : since_r + {15'h0, since_r != 16'hFFFF};
    pu_nxt    = pu_r && !evt;
    lowc_nxt  = (config_request_n && !cfg_ok_line) ? lowc_r + {15'h0, lowc_r != 16'hFFFF} : 16'h0;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_r <= 16'h0;
      lowc_r  <= 16'h0;
      pu_r    <= 1'b1;
      req_q_r <= 1'b1;
    end else begin
      since_r <= since_nxt;
      lowc_r  <= lowc_nxt;
      pu_r    <= pu_nxt;
      req_q_r <= config_request_n;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req_low;
    !config_request_n [*8];
  endsequence
  sequence s_restart;
    jtag_cmd_valid && jtag_cmd == CCS_CMD_RESTART;
  endsequence
  sequence s_io;
    jtag_cmd_valid && jtag_cmd == CCS_CMD_IO_LOAD;
  endsequence
  por_low_a: assert property ($past(sys_rst) |-> !cfg_ok_line [*8])
    else $error("status not held low after reset");
  done_fall_a: assert property ($fell(config_request_n) |-> ##[0:6] !load_complete)
    else $error("load_complete slow to fall");
  status_fall_a: assert property ($fell(config_request_n) |-> ##[0:6] !cfg_ok_line)
    else $error("status slow to fall");
  req_hold_a: assert property (s_req_low |-> !load_complete && !cfg_ok_line)
    else $error("lines high while request low");
  status_pulse_a: assert property (lowc_r <= REL_MAX)
    else $error("status held low too long");
  first_clk_a: assert property ($rose(load_clock) |-> since_r >= WAIT_L)
    else $error("load clock too early");
  io_high_a: assert property (s_io |-> config_request_n)
    else $error("chain load while request low");
  io_wait_a: assert property (s_io |-> since_r >= WAIT_L || (pu_r && cfg_ok_line))
    else $error("chain load too early");
  park_clk_a: assert property (load_complete [*8] |-> !load_clock)
    else $error("load clock not parked");
  restart_drop_a: assert property (s_restart |-> ##[1:8] !cfg_ok_line)
    else $error("restart did not drop status");
endmodule : ccs_link_chk

// ==== ccs_link_if.sv ====
// Pins between the configuration host and the device
`timescale 1ns/100ps
interface ccs_link_if;
  import ccs_pkg::*;
  logic          config_request_n;
  logic          load_clock;
  ccs_byte_t     load_data;
  logic          chip_select_in_n;
  ccs_jtag_cmd_t jtag_cmd;
  logic          jtag_cmd_valid;
  logic          dev_ok_o;
  logic          dev_ok_oe_n;
  logic          dev_done_o;
  logic          dev_done_oe_n;
  logic          host_ok_o;
  logic          host_ok_oe_n;
  logic          host_done_o;
  logic          host_done_oe_n;
  logic          cfg_ok_line;
  logic          load_complete;
  // Open-drain wired AND with pull-up
  assign cfg_ok_line   = !((!dev_ok_oe_n && !dev_ok_o) || (!host_ok_oe_n && !host_ok_o));
  assign load_complete = !((!dev_done_oe_n && !dev_done_o) || (!host_done_oe_n && !host_done_o));
  modport device (input config_request_n, load_clock, load_data, chip_select_in_n,
                  jtag_cmd, jtag_cmd_valid, cfg_ok_line, load_complete,
                  output dev_ok_o, dev_ok_oe_n, dev_done_o, dev_done_oe_n);
  modport host (output config_request_n, load_clock, load_data, chip_select_in_n,
                jtag_cmd, jtag_cmd_valid, host_ok_o, host_ok_oe_n, host_done_o, host_done_oe_n,
                input cfg_ok_line, load_complete);
endinterface : ccs_link_if

// ==== ccs_params.svh ====
// Timing counts and widths shared by both ends of the configuration link
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_CLK_PERIOD_NS      8
`define CCS_STATUS_MAX_US      230
`define CCS_STATUS_MAX_CYC     ((`CCS_STATUS_MAX_US * 1000) / `CCS_CLK_PERIOD_NS)
`define CCS_LATE_REL_US        200
`define CCS_LATE_REL_CYC       ((`CCS_LATE_REL_US * 1000) / `CCS_CLK_PERIOD_NS)
`define CCS_POR_US             100
`define CCS_POR_CYC            ((`CCS_POR_US * 1000) / `CCS_CLK_PERIOD_NS)
`define CCS_WAIT_MIN_US        230
`define CCS_WAIT_MIN_CYC       ((`CCS_WAIT_MIN_US * 1000 + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`define CCS_CFG_LOW_NS         500
`define CCS_CFG_LOW_CYC        ((`CCS_CFG_LOW_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`define CCS_LCLK_HALF_CYC      8
`define CCS_CNT_W              16
`define CCS_BYTE_CNT_W         16
`define CCS_BSR_SMALL          1006
`define CCS_BSR_LARGE          1495
`define CCS_BSR_W              11
`endif

// ==== ccs_pkg.sv ====
// Types shared by both ends of the configuration link
package ccs_pkg;
  typedef logic [7:0] ccs_byte_t;
  typedef enum logic [1:0] {
    CCS_CMD_NONE,
    CCS_CMD_RESTART,
    CCS_CMD_ENGAGE,
    CCS_CMD_IO_LOAD
  } ccs_jtag_cmd_t;
endpackage : ccs_pkg

// ==== config_control_sequencer_tb.sv ====
// Testbench joining host and device ends of the configuration link
`timescale 1ns/100ps
`include "ccs_params.svh"
module config_control_sequencer_tb;
  import ccs_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  start_cfg = 1'b0;
  logic                  jtag_restart_req = 1'b0;
  logic                  jtag_engage_req = 1'b0;
  logic                  io_load_req = 1'b0;
  logic                  tx_valid = 1'b0;
  ccs_byte_t             tx_byte = 8'h00;
  logic                  tx_ready, host_busy, io_load_refused;
  logic                  user_mode, loader_active, cfg_byte_valid, io_chain_reload;
  ccs_byte_t             cfg_byte, user_io_in, b;
  logic [`CCS_BSR_W-1:0] bsr_length;
  int                    n_fail = 0, n_compared = 0, n_reload = 0, n_refused = 0;
  int                    cyc = 0, seed = 17912, k;
  ccs_byte_t             exp_q[$];
  always #4 sys_clk = ~sys_clk;
  ccs_link_if link ();
  ccs_device #(.POR_CYC(20), .STATUS_CYC(20)) ccs_device_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .user_mode(user_mode),
    .loader_active(loader_active), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
    .user_io_in(user_io_in), .io_chain_reload(io_chain_reload), .bsr_length(bsr_length));
  ccs_host #(.WAIT_CYC(40)) ccs_host_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .start_cfg(start_cfg),
    .jtag_restart_req(jtag_restart_req), .jtag_engage_req(jtag_engage_req),
    .io_load_req(io_load_req), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .host_busy(host_busy), .io_load_refused(io_load_refused));
  // Checker defaults already match the shortened device and host timings
  ccs_link_chk ccs_link_chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .config_request_n(link.config_request_n),
    .load_clock(link.load_clock), .jtag_cmd(link.jtag_cmd), .jtag_cmd_valid(link.jtag_cmd_valid),
    .cfg_ok_line(link.cfg_ok_line), .load_complete(link.load_complete));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Valid stays up across bytes so the strobe never toggles twice in one step
  task automatic send_cfg();
    start_cfg = 1'b1;
    tick(1);
    start_cfg = 1'b0;
    tx_valid  = 1'b1;
    for (int i = 0; i < 16; i++) begin
      tx_byte = ccs_byte_t'($random(seed));
      exp_q.push_back(tx_byte);
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (tx_ready !== 1'b1 && k < 2000);
      #1;
    end
    tx_valid = 1'b0;
    for (k = 0; k < 300 && link.load_complete !== 1'b1; k++) tick(1);
    tick(10);
    chk("load_complete", 1, 32'(link.load_complete));
    chk("user_mode", 1, 32'(user_mode));
    chk("host_busy", 0, 32'(host_busy));
    chk("bytes left", 0, exp_q.size());
  endtask : send_cfg
  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (io_chain_reload === 1'b1) n_reload++;
    if (io_load_refused === 1'b1) n_refused++;
    if (cfg_byte_valid === 1'b1) begin
      b = (exp_q.size() > 0) ? exp_q.pop_front() : ~cfg_byte;
      chk("cfg_byte", 32'(b), 32'(cfg_byte));
    end
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    tick(5);
    sys_rst     = 1'b0;
    io_load_req = 1'b1;
    tick(1);
    io_load_req = 1'b0;
    tick(8);
    chk("refused", 1, n_refused);
    chk("cfg_ok_line", 0, 32'(link.cfg_ok_line));
    chk("load_complete", 0, 32'(link.load_complete));
    chk("bsr_length", `CCS_BSR_SMALL, 32'(bsr_length));
    chk("loader_active", 1, 32'(loader_active));
    for (k = 0; k < 200 && link.cfg_ok_line !== 1'b1; k++) tick(1);
    send_cfg();
    chk("loader_active", 0, 32'(loader_active));
    chk("user_io_in", 32'(link.load_data), 32'(user_io_in));
    tick(300);
    chk("user_mode", 1, 32'(user_mode));
    io_load_req = 1'b1;
    tick(1);
    io_load_req = 1'b0;
    tick(20);
    chk("io reload", 1, n_reload);
    // Engage then restart, each followed at once by a chain load that must be turned away
    for (int j = 0; j < 2; j++) begin
      jtag_restart_req = (j == 1);
      jtag_engage_req  = (j == 0);
      tick(1);
      jtag_restart_req = 1'b0;
      jtag_engage_req  = 1'b0;
      tick(2);
      io_load_req = 1'b1;
      tick(1);
      io_load_req = 1'b0;
      tick(20);
      chk("refused", 2 + j, n_refused);
      chk("user_mode", 32'(j == 0), 32'(user_mode));
      chk("io reload", 1, n_reload);
    end
    send_cfg();
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    chk("user_mode", 0, 32'(user_mode));
    chk("loader_active", 1, 32'(loader_active));
    chk("load_complete", 0, 32'(link.load_complete));
    tick(60);
    results();
  end
endmodule : config_control_sequencer_tb
